// ### inc/dac_cmd_pkg.sv
// Shared constants and carriers for the serial DAC command decoder
package dac_cmd_pkg;

	localparam int WORD_BITS      = 16;
	localparam int CNT_BITS       = 5;
	// Program and data bit positions within the command word
	localparam int POS_TARGET_MSB = 15;
	localparam int POS_SPEED      = 14;
	localparam int POS_POWER      = 13;
	localparam int POS_TARGET_LSB = 12;
	localparam int POS_CODE_HI    = 11;
	localparam int POS_CODE_LO    = 4;
	localparam int POS_VSRC_MSB   = 1;
	localparam int POS_VSRC_LSB   = 0;

	// Reset values of the latches, and the full bit count
	localparam logic [7:0]  OUTPUT_CODE_RESET = 8'h00;
	localparam logic [1:0]  VSRC_RESET        = 2'h0;
	localparam logic [15:0] SHIFT_RESET       = 16'h0000;
	localparam logic [4:0]  COUNT_RESET       = 5'h00;
	localparam logic [4:0]  COUNT_FULL        = 5'h10;

	// Register select codes
	typedef enum logic [1:0] {
		TARGET_DAC      = 2'b00,
		TARGET_RSVD_A   = 2'b01,
		TARGET_RSVD_B   = 2'b10,
		TARGET_CONTROL  = 2'b11
	} target_t;

	// Reference source decoded from the control register
	typedef enum logic [1:0] {
		VREF_EXTERNAL = 2'b00,
		VREF_1V024    = 2'b01,
		VREF_2V048    = 2'b10
	} vref_t;

	// A complete received word, as it crosses into the system domain
	typedef struct packed {
		logic [15:0] word;
	} frame_word_t;

	// Decoded analog settings presented to the converter core
	typedef struct packed {
		logic [7:0] output_code;
		logic       fast_settling;
		logic       powered_down;
		vref_t      vref;
	} dac_setting_t;

endpackage

// ### hw/word_sync.sv
// Toggle crossing of a word from the link domain to the system domain
module word_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             src_clk,  // Link-side clock
	input  wire logic             src_rst_n, // Link-side reset, active low
	input  wire logic             src_load, // One-cycle load strobe
	input  wire logic [WIDTH-1:0] src_data, // Word to carry
	input  wire logic             dst_clk,  // System clock
	input  wire logic             dst_rst_n, // System reset, active low
	output logic                  dst_valid, // One-cycle arrival pulse
	output logic      [WIDTH-1:0] dst_data  // Carried word, registered
);
	logic             toggle;
	logic             next_toggle;
	logic [WIDTH-1:0] hold;
	logic [WIDTH-1:0] next_hold;
	logic             sync_a;
	logic             sync_b;
	logic             sync_c;
	logic [WIDTH-1:0] next_dst_data;
	logic             next_dst_valid;

	// Hold data stable while the toggle crosses; words are at least 2 link
	// clocks apart so the held value never changes mid-crossing
	always_comb begin
		next_toggle = src_load ? ~toggle : toggle;
		next_hold   = src_load ? src_data : hold;
	end

	always_ff @(posedge src_clk or negedge src_rst_n) begin
		if (!src_rst_n) begin
			toggle <= 1'b0;
			hold   <= '0;
		end else begin
			toggle <= next_toggle;
			hold   <= next_hold;
		end
	end

	// Edge of the synchronised toggle marks a new word; the pulse is
	// registered with the data so the decoder never sees a stale word
	always_comb begin
		next_dst_valid = sync_b ^ sync_c;
		next_dst_data  = next_dst_valid ? hold : dst_data;
	end

	always_ff @(posedge dst_clk or negedge dst_rst_n) begin
		if (!dst_rst_n) begin
			sync_a   <= 1'b0;
			sync_b   <= 1'b0;
			sync_c    <= 1'b0;
			dst_valid <= 1'b0;
			dst_data  <= '0;
		end else begin
			sync_a    <= toggle;
			sync_b    <= sync_a;
			sync_c    <= sync_b;
			dst_valid <= next_dst_valid;
			dst_data  <= next_dst_data;
		end
	end
endmodule

// ### hw/cmd_decode.sv
// Applies one received command word to the DAC and control latches
module cmd_decode (
	input  wire logic                       sys_clk,   // System clock
	input  wire logic                       reset_n,   // Async reset
	input  wire logic                       word_valid, // New word pulse
	input  wire logic [15:0]                word,      // Received word
	output dac_cmd_pkg::dac_setting_t       setting,   // Latched state
	output logic                            update     // Output update pulse
);
	dac_cmd_pkg::dac_setting_t next_setting;
	logic                      next_update;
	dac_cmd_pkg::target_t      target;

	// Decode register select and program bits
	always_comb begin
		target = dac_cmd_pkg::target_t'({word[dac_cmd_pkg::POS_TARGET_MSB],
			word[dac_cmd_pkg::POS_TARGET_LSB]});
		next_setting = setting;
		next_update  = 1'b0;
		if (word_valid) begin
			// Speed and power follow every word, any target
			next_setting.fast_settling =
				word[dac_cmd_pkg::POS_SPEED];
			next_setting.powered_down =
				word[dac_cmd_pkg::POS_POWER];
			next_update = 1'b1;
			case (target)
				dac_cmd_pkg::TARGET_DAC: begin
					next_setting.output_code = word[
						dac_cmd_pkg::POS_CODE_HI:
						dac_cmd_pkg::POS_CODE_LO];
				end
				dac_cmd_pkg::TARGET_CONTROL: begin
					// 11 aliases to external, like 00
					case ({word[dac_cmd_pkg::POS_VSRC_MSB],
						word[dac_cmd_pkg::POS_VSRC_LSB]})
						2'b01: next_setting.vref = dac_cmd_pkg::VREF_1V024;
						2'b10: next_setting.vref = dac_cmd_pkg::VREF_2V048;
						default: next_setting.vref =
							dac_cmd_pkg::VREF_EXTERNAL;
					endcase
				end
				default: begin
					// Reserved codes touch neither latch
					next_setting = next_setting;
				end
			endcase
		end
	end

	// Control state stays put across DAC writes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			setting.output_code   <= dac_cmd_pkg::OUTPUT_CODE_RESET;
			setting.fast_settling <= 1'b0;
			setting.powered_down  <= 1'b0;
			setting.vref          <= dac_cmd_pkg::VREF_EXTERNAL;
			update                <= 1'b0;
		end else begin
			setting <= next_setting;
			update  <= next_update;
		end
	end
endmodule

// ### hw/dac_serial_command_decoder.sv
// Serial command receiver and decoder for an 8-bit voltage-output DAC
//
// How it works
// - A command is 16 bits: four program bits, then twelve data bits.
// - Bit 14 high selects fast settling, low selects slow.
// - Bit 13 high powers down, low runs normally.
// - Bits 15 and 12 pick target: 00 DAC, 11 control, others reserved.
// - DAC write takes bits 11..4 as code; host sends zero low bits.
// - Control write uses only bits 1..0; bits 11..2 are ignored.
// - Source 00/11 external, 01 internal 1.024 V, 10 internal 2.048 V.
// - Word is taken on the rising link clock edge after bit 0; outputs update later, on the system clock.
// - Control settings persist across later DAC writes.
// - Chip select low enables; frame sync fall starts MSB-first shifting.
// - After 16 bits or an early frame sync rise, latch and update.
// - All latches clear to zero at reset.
module dac_serial_command_decoder (
	input  wire logic                  sys_clk,       // System clock
	input  wire logic                  reset_n,       // Async reset, low
	input  wire logic                  serial_clk,    // Link clock
	input  wire logic                  serial_data,   // Serial data in
	input  wire logic                  frame_sync,    // Frame sync, falls
	input  wire logic                  chip_select_n, // Enable, active low
	output logic                 [7:0] output_code,   // Applied DAC code
	output logic                       settling_speed_select, // 1 fast
	output logic                       power_down_select,     // 1 down
	output logic                 [1:0] voltage_source, // Reference source
	output logic                       output_update  // Update pulse
);
	// Link-domain state, falling edge of the serial clock
	logic [15:0] shift;
	logic [15:0] next_shift;
	logic [4:0]  count;
	logic [4:0]  next_count;
	logic        active;
	logic        next_active;
	logic        fs_prev;
	logic        next_fs_prev;
	// Word-finished request, handed straight to the crossing
	logic        done_req;
	logic        next_done_req;
	// Link-side reset, released on the link clock
	logic        link_rst_a;
	logic        link_rst_n;

	logic        word_valid;
	logic [15:0] word;
	dac_cmd_pkg::dac_setting_t setting;

	// Reset release synchronised into the link domain
	always_ff @(posedge serial_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_rst_a <= 1'b0;
			link_rst_n <= 1'b0;
		end else begin
			link_rst_a <= 1'b1;
			link_rst_n <= link_rst_a;
		end
	end

	// Shifter sampled on falling serial clock; frame sync and data are
	// sampled on the link clock itself, which is their own timing domain
	always_comb begin
		next_shift   = shift;
		next_count   = count;
		next_active  = active;
		next_fs_prev = frame_sync;
		next_done_req = 1'b0;
		if (chip_select_n) begin
			// Deselected device ignores the link
			next_active = 1'b0;
			next_count  = dac_cmd_pkg::COUNT_RESET;
		end else if (fs_prev && !frame_sync) begin
			// Frame start: first bit is the MSB, sampled now
			next_active = 1'b1;
			next_shift  = {shift[14:0], serial_data};
			next_count  = 5'h01;
		end else if (active && frame_sync) begin
			// Early frame sync rise ends the word
			next_active   = 1'b0;
			next_done_req = 1'b1;
		end else if (active) begin
			next_shift = {shift[14:0], serial_data};
			next_count = count + 5'h01;
		end
		if (active && next_active &&
			next_count == dac_cmd_pkg::COUNT_FULL) begin
			next_active   = 1'b0;
			next_done_req = 1'b1;
		end
	end

	always_ff @(negedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift    <= dac_cmd_pkg::SHIFT_RESET;
			count    <= dac_cmd_pkg::COUNT_RESET;
			active   <= 1'b0;
			fs_prev  <= 1'b1;
			done_req <= 1'b0;
		end else begin
			shift    <= next_shift;
			count    <= next_count;
			active   <= next_active;
			fs_prev  <= next_fs_prev;
			done_req <= next_done_req;
		end
	end

	// Word crosses into the system clock domain; the crossing takes the
	// word on the rising edge right after bit 0, so no further link edge
	// is needed once the host parks its clock
	word_sync #(
		.WIDTH(dac_cmd_pkg::WORD_BITS)
	) u_sync (
		.src_clk  (serial_clk),
		.src_rst_n(link_rst_n),
		.src_load (done_req),
		.src_data (shift),
		.dst_clk  (sys_clk),
		.dst_rst_n(reset_n),
		.dst_valid(word_valid),
		.dst_data (word)
	);

	// Decode the word into the latches; reference pin use is the
	// host's duty, nothing here checks it
	cmd_decode u_decode (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.word_valid(word_valid),
		.word      (word),
		.setting   (setting),
		.update    (output_update)
	);

	// Latched state out to the analog core
	always_comb begin
		output_code           = setting.output_code;
		settling_speed_select = setting.fast_settling;
		power_down_select     = setting.powered_down;
		voltage_source        = setting.vref;
	end
endmodule

// ### test/dac_cmd_props.sv
// Checker for the serial DAC command decoder ports
module dac_cmd_props (
	input wire logic       sys_clk,       // System clock
	input wire logic       reset_n,       // Async reset
	input wire logic       serial_clk,    // Link clock
	input wire logic       serial_data,   // Serial data
	input wire logic       frame_sync,    // Frame sync
	input wire logic       chip_select_n, // Enable
	input wire logic [7:0] output_code,   // Code
	input wire logic       settling_speed_select, // Speed
	input wire logic       power_down_select,     // Power
	input wire logic [1:0] voltage_source, // Source
	input wire logic       output_update  // Pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sh;
	logic [15:0] got;
	logic [4:0]  n;
	wire         dac = output_update && !got[15] && !got[12];
	wire         ctl = output_update && got[15] && got[12];
	wire         rsv = output_update && (got[15] != got[12]);
	wire [11:0]  outs = {output_code, settling_speed_select,
		power_down_select, voltage_source};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Rebuild each word off the wire; the shifter is never cleared, so an
	// early end commits the new bits under whatever older bits remain
	always_ff @(negedge serial_clk or negedge reset_n) begin
		if (!reset_n) begin
			n   <= 5'h00;
			sh  <= 16'h0000;
			got <= 16'h0000;
		end else if (chip_select_n || frame_sync) begin
			if (!chip_select_n && n != 5'h00 && n < 5'h10)
				got <= sh;
			n  <= 5'h00;
		end else begin
			n  <= n + 5'h01;
			sh <= {sh[14:0], serial_data};
			if (n == 5'h0f)
				got <= {sh[14:0], serial_data};
		end
	end
	a_update_gap: assert property (
		output_update |=> !output_update [*8])
		else $error("update pulse too long");
	a_quiet_hold: assert property ($changed(outs) |-> output_update)
		else $error("outputs moved without update");
	a_source_legal: assert property (voltage_source != 2'b11)
		else $error("source code 11 shown");
	a_code_from_word: assert property (
		dac |-> output_code == got[11:4])
		else $error("code not taken from word");
	a_speed_power: assert property (output_update |->
		settling_speed_select == got[14] && power_down_select == got[13])
		else $error("speed or power wrong");
	a_control_source: assert property (ctl |-> voltage_source ==
		((got[1:0] == 2'b11) ? 2'b00 : got[1:0]))
		else $error("source decode wrong");
	a_reserved_keep: assert property (rsv |->
		$stable(output_code) && $stable(voltage_source))
		else $error("reserved write changed state");
	a_dac_keeps_src: assert property (
		dac |-> $stable(voltage_source))
		else $error("source lost on code write");
	a_ctl_keeps_code: assert property (ctl |-> $stable(output_code))
		else $error("code changed on control write");
	c_dac: cover property (dac);
	c_ctl: cover property (ctl);
	c_rsv: cover property (rsv);
endmodule

bind dac_serial_command_decoder dac_cmd_props chk (.sys_clk, .reset_n,
	.serial_clk, .serial_data, .frame_sync, .chip_select_n, .output_code,
	.settling_speed_select, .power_down_select, .voltage_source,
	.output_update);

// ### test/serial_host_model.sv
// Host serial port model driving command words into the decoder
module serial_host_model (
	output logic serial_clk,    // Link clock, still between frames
	output logic serial_data,   // Command bits, MSB first
	output logic frame_sync,    // Frame marker, falls to start
	output logic chip_select_n  // Device enable, active low
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle: clock parked high, device deselected
	initial begin
		serial_clk    = 1'b1;
		serial_data   = 1'b0;
		frame_sync    = 1'b1;
		chip_select_n = 1'b1;
	end
	// k link periods of 64 ns each, falling edge first
	task automatic tick(input int k);
		repeat (k) begin
			#32 serial_clk = 1'b0;
			#32 serial_clk = 1'b1;
		end
	endtask
	// Top k bits of w; cut drops the select instead of ending the frame
	task automatic send(input logic [15:0] w, input int k, input bit cut);
		// Offset keeps link edges away from the system clock edges
		#3;
		chip_select_n = 1'b0;
		frame_sync    = 1'b1;
		tick(1);
		for (int i = 0; i < k; i++) begin
			frame_sync  = 1'b0;
			serial_data = w[15-i];
			tick(1);
		end
		chip_select_n = cut;
		frame_sync    = 1'b1;
		serial_data   = ~serial_data; // Released line, not a held value
		tick(1);
		chip_select_n = 1'b1;
	endtask
endmodule

// ### test/dac_serial_command_decoder_test.sv
// Self-checking bench for the serial DAC command decoder
module dac_serial_command_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [15:0] w;
		logic [11:0] e;
	} row_t;
	logic       sys_clk, reset_n, serial_clk, serial_data;
	logic       frame_sync, chip_select_n, output_update;
	logic       settling_speed_select, power_down_select;
	logic [7:0] output_code;
	logic [1:0] voltage_source;
	int         failures, num_checks, ups;
	row_t       rows [8];
	wire [11:0] outs = {output_code, settling_speed_select,
		power_down_select, voltage_source};
	serial_host_model host (.serial_clk, .serial_data, .frame_sync,
		.chip_select_n);
	dac_serial_command_decoder uut (.sys_clk, .reset_n, .serial_clk,
		.serial_data, .frame_sync, .chip_select_n, .output_code,
		.settling_speed_select, .power_down_select, .voltage_source,
		.output_update);
	// 125 MHz system clock
	always #4 sys_clk = ~sys_clk;
	// Count pulses mid-cycle, away from the launching edge
	always @(negedge sys_clk) if (output_update === 1'b1) ups++;
	task automatic end_of_test();
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	// One word, a bounded wait for its pulse, then the applied state
	task automatic xfer(input logic [15:0] w, input int k, input bit cut,
		input logic [11:0] exp);
		int u0;
		u0 = ups;
		fork
			host.send(w, k, cut);
			for (int i = 0; i < 400 && ups == u0; i++)
				@(negedge sys_clk);
		join
		if (!cut && ups == u0) begin
			failures++;
			end_of_test();
		end
		@(negedge sys_clk);
		check(outs, exp);
		check(12'(ups - u0), {11'h000, !cut});
	endtask
	// Reset with the link clock running, then the row table
	initial begin
		rows = '{'{16'hd002, 12'h00a}, '{16'h4a50, 12'ha5a},
			'{16'h3ffd, 12'ha56}, '{16'hbfff, 12'ha54},
			'{16'h9001, 12'ha51}, '{16'hcff0, 12'ha59},
			'{16'h0ff0, 12'hff1}, '{16'h6000, 12'h00d}};
		failures = 0;
		num_checks = 0;
		sys_clk = 1'b0;
		reset_n = 1'b0;
		fork
			repeat (10) @(negedge sys_clk);
			host.tick(4);
		join
		check(outs, 12'h000);
		// Release away from any link clock edge
		@(negedge sys_clk);
		reset_n = 1'b1;
		host.tick(2);
		foreach (rows[i])
			xfer(rows[i].w, 16, 1'b0, rows[i].e);
		xfer(16'h0a00, 12, 1'b0, 12'h0a1);
		xfer(16'hd003, 8, 1'b1, 12'h0a1);
		@(negedge sys_clk);
		reset_n = 1'b0;
		fork
			repeat (3) @(negedge sys_clk);
			host.tick(2);
		join
		check(outs, 12'h000);
		@(negedge sys_clk);
		reset_n = 1'b1;
		host.tick(2);
		xfer(16'h4ff0, 16, 1'b0, 12'hff8);
		end_of_test();
	end
endmodule
